// *** src/tesc_core.sv ***
// tooth edge switching core: tracking, threshold, hysteresis, output phases
// assumes converter readings synchronous to core_clk; pin pulled up outside
//
// What this block does
// - continuously track converter samples and detect each local minimum and maximum
// - in power-on, track but ignore field; hold output high about 700 us
// - in start-up, field rising past minimum by change constant drives output low
// - in start-up, field falling past maximum by change constant validates maximum
// - with valid minimum and maximum, compute threshold and enter running phase
// - switching threshold is roughly the mean of minimum and maximum
// - threshold updates are averaged to ride out distortion yet follow run-out
// - in running, output edges follow field direction on threshold crossings
// - further switching needs an extra hysteresis crossing, fraction of amplitude
// - hysteresis stays internal, only suppressing extra switching events
// - a start-up request for high while already high changes nothing
// - running phase reached within at most three magnetic edges after start-up
// - cancel probe offset by spinning supply through four directions and averaging
// - hysteresis levels are threshold plus and minus 12.5 % of amplitude
// - positive and negative hysteresis levels must be crossed in alternation
`timescale 1ns/1ps
`include "tesc_regs.svh"
`default_nettype none

module tesc_core #(
  parameter int W               = `TESC_SAMPLE_W,
  parameter int MIN_CHANGE      = `TESC_MIN_CHANGE,
  parameter int POWER_ON_CYCLES = `TESC_POWER_ON_NS / `TESC_CLK_PERIOD_NS
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic signed [W-1:0] conv_sample,
  input  wire logic                conv_valid,
  input  wire logic                q_in,
  output var  logic [1:0]          spin_dir,
  output var  tesc_pkg::tesc_od_pin_t q_pin,
  output var  logic                q_level,
  output var  tesc_pkg::tesc_phase_t  phase
);

  localparam int PW = $clog2(POWER_ON_CYCLES + 1);
  localparam logic signed [W:0] MIN_DELTA = (W+1)'(MIN_CHANGE);

  // elaboration check of parameters
  if (W < 4 || MIN_CHANGE < 1 || MIN_CHANGE >= (1 << (W - 1)) || POWER_ON_CYCLES < 1) begin : g_bad
    $error("tesc_core: unsupported parameter values");
  end

  typedef struct packed {
    tesc_pkg::tesc_phase_t phase;
    logic [PW-1:0]         pon_cnt;
    logic                  q;
    logic                  q_oe;
    logic                  q_seen;
    logic                  dir_known;
    logic                  dir_up;
    logic signed [W-1:0]   ext_lo;
    logic signed [W-1:0]   ext_hi;
    logic signed [W-1:0]   min_v;
    logic signed [W-1:0]   max_v;
    logic                  min_ok;
    logic                  max_ok;
    logic signed [W-1:0]   thr;
    logic signed [W:0]     hyst;
    logic                  last_pos;
    logic [1:0]            mag_edges;
  } tesc_state_t;

  tesc_state_t st;
  tesc_state_t next_st;

  logic signed [W-1:0] s_avg;
  logic                s_valid;
  logic                ev_min;
  logic                ev_max;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // signed difference a - b one bit wider
  function automatic logic signed [W:0] tesc_diff(input logic signed [W-1:0] a,
                                                  input logic signed [W-1:0] b);
    tesc_diff = {a[W-1], a} - {b[W-1], b};
  endfunction

  // midpoint of two samples
  function automatic logic signed [W-1:0] tesc_mid(input logic signed [W-1:0] a,
                                                   input logic signed [W-1:0] b);
    logic signed [W:0] sum;
    sum = {a[W-1], a} + {b[W-1], b};
    tesc_mid = W'(sum >>> 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // offset cancellation front end
  tesc_spin_avg #(
    .W (W)
  ) u_spin (
    .core_clk  (core_clk),
    .reset     (reset),
    .raw       (conv_sample),
    .raw_valid (conv_valid),
    .spin_dir  (spin_dir),
    .avg       (s_avg),
    .avg_valid (s_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic signed [W-1:0] lo;
    logic signed [W-1:0] hi;
    logic signed [W:0]   amp;
    logic signed [W:0]   step;
    logic signed [W-1:0] tgt;
    lo   = (s_avg < st.ext_lo) ? s_avg : st.ext_lo;
    hi   = (s_avg > st.ext_hi) ? s_avg : st.ext_hi;
    amp  = '0;
    step = '0;
    tgt  = '0;
    ev_min  = 1'b0;
    ev_max  = 1'b0;
    next_st = st;
    next_st.q_seen = q_in;

    // power-on hold timer
    if (st.phase == tesc_pkg::TESC_PH_POWER_ON) begin
      next_st.q = 1'b1;
      if (st.pon_cnt == PW'(POWER_ON_CYCLES - 1)) begin
        next_st.phase = tesc_pkg::TESC_PH_STARTUP;
      end else begin
        next_st.pon_cnt = st.pon_cnt + 1'b1;
      end
    end

    // peak tracker, active in every phase
    if (s_valid) begin
      if (!st.dir_known) begin
        next_st.ext_lo = lo;
        next_st.ext_hi = hi;
        if (tesc_diff(s_avg, lo) > MIN_DELTA) begin
          ev_min = 1'b1;
        end else if (tesc_diff(hi, s_avg) > MIN_DELTA) begin
          ev_max = 1'b1;
        end
      end else if (st.dir_up) begin
        next_st.ext_hi = hi;
        ev_max = tesc_diff(hi, s_avg) > MIN_DELTA;
      end else begin
        next_st.ext_lo = lo;
        ev_min = tesc_diff(s_avg, lo) > MIN_DELTA;
      end
      if (ev_min) begin
        next_st.dir_known = 1'b1;
        next_st.dir_up    = 1'b1;
        next_st.ext_hi    = s_avg;
      end
      if (ev_max) begin
        next_st.dir_known = 1'b1;
        next_st.dir_up    = 1'b0;
        next_st.ext_lo    = s_avg;
      end
    end

    // extrema become valid once the field is trusted
    if (st.phase != tesc_pkg::TESC_PH_POWER_ON) begin
      if (ev_min) begin
        next_st.min_v  = lo;
        next_st.min_ok = 1'b1;
      end
      if (ev_max) begin
        next_st.max_v  = hi;
        next_st.max_ok = 1'b1;
      end
    end

    unique case (st.phase)
      tesc_pkg::TESC_PH_POWER_ON: begin
        // field ignored for switching
      end
      tesc_pkg::TESC_PH_STARTUP: begin
        if (ev_min) begin
          next_st.q = 1'b0;
        end
        if (ev_max) begin
          next_st.q = 1'b1;
        end
        if (ev_min || ev_max) begin
          next_st.mag_edges = st.mag_edges + 2'h1;
        end
        if (next_st.min_ok && next_st.max_ok) begin
          amp = tesc_diff(next_st.max_v, next_st.min_v);
          next_st.thr      = tesc_mid(next_st.max_v, next_st.min_v);
          next_st.hyst     = amp >>> `TESC_HYST_SHIFT;
          next_st.last_pos = next_st.q;
          next_st.phase    = tesc_pkg::TESC_PH_RUNNING;
        end
      end
      tesc_pkg::TESC_PH_RUNNING: begin
        // hysteresis arming, alternate crossings only
        if (s_valid) begin
          if (!st.last_pos && tesc_diff(s_avg, st.thr) > st.hyst) begin
            next_st.last_pos = 1'b1;
          end else if (st.last_pos && tesc_diff(st.thr, s_avg) > st.hyst) begin
            next_st.last_pos = 1'b0;
          end
          // threshold crossings, direction sets edge polarity
          if (st.q && !st.last_pos && s_avg > st.thr) begin
            next_st.q = 1'b0;
          end else if (!st.q && st.last_pos && s_avg < st.thr) begin
            next_st.q = 1'b1;
          end
        end
        // averaged threshold and adaptive hysteresis on new extrema
        if (ev_min || ev_max) begin
          amp  = tesc_diff(next_st.max_v, next_st.min_v);
          tgt  = tesc_mid(next_st.max_v, next_st.min_v);
          step = tesc_diff(tgt, st.thr) >>> `TESC_AVG_SHIFT;
          next_st.thr  = W'({st.thr[W-1], st.thr} + step);
          next_st.hyst = amp >>> `TESC_HYST_SHIFT;
        end
      end
      default: begin
        next_st.phase = tesc_pkg::TESC_PH_POWER_ON;
      end
    endcase
    // pin enable registered alongside the output level
    next_st.q_oe = ~next_st.q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st       <= '0;
      st.q     <= `TESC_Q_RESET;
      st.phase <= tesc_pkg::TESC_PH_POWER_ON;
      // extremes start at the far ends so the first reading sets both
      st.ext_lo <= {1'b0, {(W-1){1'b1}}};
      st.ext_hi <= {1'b1, {(W-1){1'b0}}};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state; q high releases the open-drain pin
  assign q_pin.out = 1'b0;
  assign q_pin.oe  = st.q_oe;
  assign q_level   = st.q_seen;
  assign phase     = st.phase;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic [PW:0] cyc;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cyc <= '0;
    end else if (cyc <= (PW+1)'(POWER_ON_CYCLES)) begin
      cyc <= cyc + 1'b1;
    end
  end

  sequence s_startup_min;
    st.phase == tesc_pkg::TESC_PH_STARTUP && ev_min && !ev_max;
  endsequence

  sequence s_startup_max;
    st.phase == tesc_pkg::TESC_PH_STARTUP && ev_max;
  endsequence

  sequence s_run_steady;
    st.phase == tesc_pkg::TESC_PH_RUNNING [*2];
  endsequence

  property p_pon_high;
    st.phase == tesc_pkg::TESC_PH_POWER_ON |-> st.q && !q_pin.oe;
  endproperty
  a_pon_high: assert property (p_pon_high) else $error("output not released in power-on");

  property p_pon_len;
    st.phase != tesc_pkg::TESC_PH_POWER_ON |-> cyc >= (PW+1)'(POWER_ON_CYCLES);
  endproperty
  a_pon_len: assert property (p_pon_len) else $error("power-on phase left early");

  property p_start_low;
    s_startup_min |=> !st.q ##1 q_pin.oe == 1'b1;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start-up minimum did not drive low");

  property p_start_high;
    s_startup_max |=> st.q;
  endproperty
  a_start_high: assert property (p_start_high) else $error("start-up maximum did not release");

  property p_run_entry;
    $rose(st.phase == tesc_pkg::TESC_PH_RUNNING) |->
      st.min_ok && st.max_ok && st.thr == tesc_mid(st.max_v, st.min_v);
  endproperty
  a_run_entry: assert property (p_run_entry) else $error("running entered without extrema");

  property p_run_edges;
    $rose(st.phase == tesc_pkg::TESC_PH_RUNNING) |->
      st.mag_edges != 2'h0 && st.mag_edges <= 2'(`TESC_START_EDGES_MAX);
  endproperty
  a_run_edges: assert property (p_run_edges) else $error("too many edges before running");

  property p_fall_dir;
    s_run_steady ##0 $fell(st.q) |-> $past(s_avg) > $past(st.thr) && $past(s_valid);
  endproperty
  a_fall_dir: assert property (p_fall_dir) else $error("falling edge without rising crossing");

  property p_alternate;
    s_run_steady ##0 $changed(st.q) |-> $past(st.last_pos) != $past(st.q);
  endproperty
  a_alternate: assert property (p_alternate) else $error("edge released without hysteresis");

  property p_hyst_amp;
    st.phase == tesc_pkg::TESC_PH_RUNNING && $changed(st.hyst) |->
      st.hyst == (tesc_diff(st.max_v, st.min_v) >>> `TESC_HYST_SHIFT);
  endproperty
  a_hyst_amp: assert property (p_hyst_amp) else $error("hysteresis not an eighth of amplitude");

endmodule

`default_nettype wire

// *** src/tesc_regs.svh ***
// named constants of the tooth edge switching core
// assumes inclusion by bare name from the design files
`ifndef TESC_REGS_SVH
`define TESC_REGS_SVH

// clock period and power-on hold time, in ns
`define TESC_CLK_PERIOD_NS  100
`define TESC_POWER_ON_NS    700000
// default converter sample width and minimum signal change
`define TESC_SAMPLE_W       12
`define TESC_MIN_CHANGE     8
// hysteresis is amplitude / 2**shift (12.5 %)
`define TESC_HYST_SHIFT     3
// threshold follows new targets by 1 / 2**shift per extremum
`define TESC_AVG_SHIFT      1
// number of supply spin directions and its log2
`define TESC_SPIN_DIRS      4
`define TESC_SPIN_LOG2      2
// most magnetic edges allowed before the running phase
`define TESC_START_EDGES_MAX 3
// output reset value and last spin direction
`define TESC_Q_RESET        1'b1
`define TESC_SPIN_LAST      2'h3

`endif

// *** src/tesc_pkg.sv ***
// types shared by the tooth edge switching core
// assumes nothing of its surroundings
`default_nettype none

package tesc_pkg;

  // operating phase of the core
  typedef enum logic [1:0] {
    TESC_PH_POWER_ON = 2'b00,
    TESC_PH_STARTUP  = 2'b01,
    TESC_PH_RUNNING  = 2'b10
  } tesc_phase_t;

  // open-drain switching pin as seen from the core
  typedef struct packed {
    logic out;
    logic oe;
  } tesc_od_pin_t;

endpackage

`default_nettype wire

// *** src/tesc_spin_avg.sv ***
// four-direction spinning offset cancellation for the hall probe
// assumes one converter reading per raw_valid, taken in the current direction
`timescale 1ns/1ps
`include "tesc_regs.svh"
`default_nettype none

module tesc_spin_avg #(
  parameter int W = `TESC_SAMPLE_W
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic signed [W-1:0] raw,
  input  wire logic                raw_valid,
  output var  logic [1:0]          spin_dir,
  output var  logic signed [W-1:0] avg,
  output var  logic                avg_valid
);

  typedef struct packed {
    logic [1:0]              dir;
    logic signed [W+1:0]     sum;
    logic signed [W-1:0]     avg;
    logic                    valid;
  } tesc_spin_state_t;

  tesc_spin_state_t st;
  tesc_spin_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // rotate supply and average one reading per direction
  always_comb begin
    logic signed [W+1:0] acc;
    acc = st.sum + {{2{raw[W-1]}}, raw};
    next_st = st;
    next_st.valid = 1'b0;
    if (raw_valid) begin
      next_st.dir = st.dir + 2'h1;
      if (st.dir == `TESC_SPIN_LAST) begin
        next_st.avg   = W'(acc >>> `TESC_SPIN_LOG2);
        next_st.valid = 1'b1;
        next_st.sum   = '0;
      end else begin
        next_st.sum = acc;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign spin_dir  = st.dir;
  assign avg       = st.avg;
  assign avg_valid = st.valid;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_spin_avg;
    @(posedge core_clk) disable iff (reset)
    raw_valid && st.dir == `TESC_SPIN_LAST |=> avg_valid && spin_dir == 2'h0;
  endproperty
  a_spin_avg: assert property (p_spin_avg) else $error("average not after fourth direction");

endmodule

`default_nettype wire

// *** dv/tesc_ctrl_model.sv ***
// controller side of the open-drain switching pin, with its pull-up
// assumes the core sinks the pin only while q_pin.oe is high
`timescale 1ns/1ps
`default_nettype none

module tesc_ctrl_model (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire tesc_pkg::tesc_od_pin_t q_pin,
  output var  logic                   line,
  output var  logic [7:0]             falls
);
  logic line_d;

  ////////////////////////////////////////////////////////////////////////////////
  // pull-up wins unless the core sinks the pin
  assign line = (q_pin.oe && !q_pin.out) ? 1'h0 : 1'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // count visible falling edges since reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      falls  <= 8'h00;
      line_d <= 1'h1;
    end else begin
      line_d <= line;
      if (line_d && !line) begin
        falls <= falls + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** dv/tesc_core_tb.sv ***
// self-checking bench of the tooth edge switching core
// assumes the core, its package and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tesc_regs.svh"

module tesc_core_tb;
  localparam int W  = `TESC_SAMPLE_W;
  localparam int PO = 20;

  logic                   core_clk;
  logic                   reset;
  logic signed [W-1:0]    conv_sample;
  logic                   conv_valid;
  logic                   line;
  logic [1:0]             spin_dir;
  tesc_pkg::tesc_od_pin_t q_pin;
  logic                   q_level;
  tesc_pkg::tesc_phase_t  phase;
  logic [7:0]             falls;
  int                     failures;
  int                     num_checks;
  int                     k;
  bit                     gap;
  logic                   prev_oe;
  logic                   prev_line;
  logic                   prev_rst;
  tesc_pkg::tesc_phase_t  prev_ph;
  logic                   exp_oe;
  tesc_pkg::tesc_phase_t  exp_ph;
  logic                   q_exp[$];
  tesc_pkg::tesc_phase_t  ph_exp[$];

  ////////////////////////////////////////////////////////////////////////////////
  // clock and instances
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  tesc_core #(.POWER_ON_CYCLES(PO)) i_tesc_core (
    .core_clk    (core_clk),
    .reset       (reset),
    .conv_sample (conv_sample),
    .conv_valid  (conv_valid),
    .q_in        (line),
    .spin_dir    (spin_dir),
    .q_pin       (q_pin),
    .q_level     (q_level),
    .phase       (phase)
  );

  tesc_ctrl_model i_tesc_ctrl_model (
    .core_clk (core_clk),
    .reset    (reset),
    .q_pin    (q_pin),
    .line     (line),
    .falls    (falls)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare, report, finish
  task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus tasks
  task do_reset;
    // let the monitor see the last change before reset hides it
    if (!reset) begin
      @(posedge core_clk);
      #1;
      check(8'(q_exp.size()), 8'h00, "switch notes left at reset");
    end
    reset = 1'h1;
    k = 0;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'h0;
    ph_exp.push_back(tesc_pkg::TESC_PH_STARTUP);
  endtask

  task wait_ph(input tesc_pkg::tesc_phase_t p);
    int n;
    n = 0;
    while (phase !== p) begin
      if (n == 200) begin
        failures++;
        test_done();
      end
      n++;
      @(posedge core_clk);
      #1;
    end
  endtask

  // four readings with zero-sum spin offsets, then expected output changes
  task feed(input int v, input int eq, input int ep);
    int o;
    int p;
    int i;
    int g;
    o = $urandom_range(0, 300);
    p = $urandom_range(0, 300);
    for (i = 0; i < 4; i++) begin
      check(8'(spin_dir), 8'(k % 4), "spin direction");
      conv_sample = W'(v + (i[1] ? p : o) * (i[0] ? -1 : 1));
      conv_valid = 1'h1;
      @(posedge core_clk);
      #1;
      k++;
    end
    conv_valid = 1'h0;
    if (eq >= 0) q_exp.push_back(eq[0]);
    if (ep >= 0) ph_exp.push_back(tesc_pkg::tesc_phase_t'(ep[1:0]));
    g = gap ? $urandom_range(1, 3) : 1;
    repeat (g) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each output change takes the oldest note
  always @(posedge core_clk) begin
    #5;
    if (!reset) begin
      if (q_pin.oe !== prev_oe) begin
        exp_oe = q_exp.size() ? q_exp.pop_front() : prev_oe;
        check(8'(q_pin.oe), 8'(exp_oe), "switch");
      end
      if (phase !== prev_ph) begin
        exp_ph = ph_exp.size() ? ph_exp.pop_front() : prev_ph;
        check(8'(phase), 8'(exp_ph), "phase");
      end
      check(8'(q_pin.out), 8'h00, "pin drive level");
      if (!prev_rst) check(8'(q_level), 8'(prev_line), "pin echo");
    end
    prev_oe = q_pin.oe;
    prev_ph = phase;
    prev_line = line;
    prev_rst = reset;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    conv_sample = '0;
    conv_valid = 1'h0;
    reset = 1'h1;
    failures = 0;
    num_checks = 0;
    gap = 1'b0;
    prev_oe = 1'h0;
    prev_line = 1'h1;
    prev_rst = 1'h1;
    prev_ph = tesc_pkg::TESC_PH_POWER_ON;
    void'($urandom(32'hBF4B));
    do_reset();
    // swings during power-on must not switch
    feed(100, -1, -1);
    feed(-100, -1, -1);
    feed(100, -1, -1);
    check(8'(phase), 8'(tesc_pkg::TESC_PH_POWER_ON), "power-on hold");
    wait_ph(tesc_pkg::TESC_PH_STARTUP);
    check(falls, 8'h00, "power-on output high");
    // second reset in mid-run, then start-up from a minimum
    do_reset();
    gap = 1'b1;
    wait_ph(tesc_pkg::TESC_PH_STARTUP);
    feed(-100, -1, -1);
    feed(-50, 1, -1);
    feed(50, -1, -1);
    feed(100, -1, -1);
    feed(60, 0, 2);
    feed(-4, -1, -1);
    feed(-60, -1, -1);
    feed(-100, -1, -1);
    feed(-50, -1, -1);
    feed(4, 1, -1);
    feed(-4, -1, -1);
    feed(4, -1, -1);
    feed(100, -1, -1);
    feed(60, -1, -1);
    feed(-4, 0, -1);
    feed(4, -1, -1);
    feed(-25, -1, -1);
    feed(4, -1, -1);
    feed(20, -1, -1);
    // start-up from a maximum: first request for high is invisible
    do_reset();
    wait_ph(tesc_pkg::TESC_PH_STARTUP);
    feed(200, -1, -1);
    feed(190, -1, -1);
    feed(-40, -1, -1);
    feed(-31, 1, 2);
    repeat (2) @(posedge core_clk);
    #1;
    check(falls, 8'h01, "one visible edge");
    check(8'(phase), 8'(tesc_pkg::TESC_PH_RUNNING), "running reached");
    feed(40, -1, -1);
    feed(200, -1, -1);
    feed(120, -1, -1);
    feed(81, -1, -1);
    feed(79, 0, -1);
    feed(-120, -1, -1);
    feed(-100, -1, -1);
    feed(59, -1, -1);
    feed(61, 1, -1);
    repeat (4) @(posedge core_clk);
    #1;
    check(8'(q_exp.size()), 8'h00, "pending switch notes");
    check(8'(ph_exp.size()), 8'h00, "pending phase notes");
    test_done();
  end
endmodule

`default_nettype wire
